// >>> hdl/bstp_pkg.sv
/*
 * Constants, instruction codes and controller states for the boundary-scan test port.
 * Assumes one test clock domain driven by the tester and one core domain on ref_clk.
 */
package bstp_pkg;

	// ----------------------------------------------------------------
	// Register widths and chain layout
	// ----------------------------------------------------------------
	localparam int IR_W        = 6;
	localparam int ID_W        = 32;
	localparam int RX_LANES    = 4;
	localparam int TX_LANES    = 4;
	localparam int CHAIN_RX_LO = 0;
	localparam int CHAIN_TX_LO = RX_LANES;
	localparam int CHAIN_CTL   = RX_LANES + TX_LANES;
	localparam int CHAIN_W     = RX_LANES + TX_LANES + 1;
	localparam int UPD_W       = TX_LANES + 1;

	// ----------------------------------------------------------------
	// Instruction codes and reset values
	// ----------------------------------------------------------------
	localparam logic [IR_W-1:0] INS_EXTEST  = 6'h00;
	localparam logic [IR_W-1:0] INS_SAMPLE  = 6'h01;
	localparam logic [IR_W-1:0] INS_IDCODE  = 6'h02;
	localparam logic [IR_W-1:0] INS_BYPASS  = 6'h3F;
	localparam logic [IR_W-1:0] IR_CAPTURE  = 6'h01;
	localparam logic            BYP_CAPTURE = 1'h0;

	// Arbitrary neutral identification value; bit 0 is one as the serial protocol requires
	localparam logic [ID_W-1:0] ID_VALUE    = 32'h0000_0001;

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	localparam int TLR_ONES   = 5;
	localparam int SYNC_DEPTH = 2;

	// ----------------------------------------------------------------
	// Controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_TLR    = 4'h0,
		ST_RTI    = 4'h1,
		ST_SELDR  = 4'h2,
		ST_CAPDR  = 4'h3,
		ST_SHDR   = 4'h4,
		ST_EX1DR  = 4'h5,
		ST_PAUSDR = 4'h6,
		ST_EX2DR  = 4'h7,
		ST_UPDDR  = 4'h8,
		ST_SELIR  = 4'h9,
		ST_CAPIR  = 4'hA,
		ST_SHIR   = 4'hB,
		ST_EX1IR  = 4'hC,
		ST_PAUSIR = 4'hD,
		ST_EX2IR  = 4'hE,
		ST_UPDIR  = 4'hF
	} bstp_state_t;

endpackage : bstp_pkg

// >>> hdl/bstp_tap_ctrl.sv
/*
 * Sixteen-state test access controller stepped by the mode select on each test clock.
 * Assumes the tester sets the mode select ahead of every rising test clock edge.
 */
`timescale 1ns/1ps

module bstp_tap_ctrl
	import bstp_pkg::*;
(
	input  wire logic        tck,
	input  wire logic        testRstN,
	input  wire logic        tms,
	output bstp_state_t      tapState
);

	bstp_state_t state_d;
	bstp_state_t state_q;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_TLR:    state_d = tms ? ST_TLR   : ST_RTI;   // R07
			ST_RTI:    state_d = tms ? ST_SELDR : ST_RTI;
			ST_SELDR:  state_d = tms ? ST_SELIR : ST_CAPDR;
			ST_CAPDR:  state_d = tms ? ST_EX1DR : ST_SHDR;
			ST_SHDR:   state_d = tms ? ST_EX1DR : ST_SHDR;
			ST_EX1DR:  state_d = tms ? ST_UPDDR : ST_PAUSDR;
			ST_PAUSDR: state_d = tms ? ST_EX2DR : ST_PAUSDR;
			ST_EX2DR:  state_d = tms ? ST_UPDDR : ST_SHDR;
			ST_UPDDR:  state_d = tms ? ST_SELDR : ST_RTI;
			ST_SELIR:  state_d = tms ? ST_TLR   : ST_CAPIR;  // R08
			ST_CAPIR:  state_d = tms ? ST_EX1IR : ST_SHIR;
			ST_SHIR:   state_d = tms ? ST_EX1IR : ST_SHIR;
			ST_EX1IR:  state_d = tms ? ST_UPDIR : ST_PAUSIR;
			ST_PAUSIR: state_d = tms ? ST_EX2IR : ST_PAUSIR;
			ST_EX2IR:  state_d = tms ? ST_UPDIR : ST_SHIR;
			ST_UPDIR:  state_d = tms ? ST_SELDR : ST_RTI;
		endcase
	end

	// Reset needs no test clock edge, so a stopped tester clock still recovers
	always_ff @(posedge tck or negedge testRstN) begin
		if (!testRstN) begin
			state_q <= ST_TLR;  // R02
		end else begin
			state_q <= state_d;  // R03
		end
	end

	assign tapState = state_q;

endmodule : bstp_tap_ctrl

// >>> hdl/bstp_test_port.sv
/*
 * Boundary-scan test port: instruction, bypass, identification and boundary-cell chain.
 * Assumes a free-running core clock ref_clk and a tester clock tck of unrelated phase.
 */
// Function
// (R01) Sixteen-state controller and six-bit instruction register, reached only by five test pins.
// (R02) Active-low test reset clears the controller without any test clock edge.
// (R03) Mode select and serial input are sampled on each rising test clock.
// (R04) Serial output changes only on the falling test clock edge.
// (R05) Serial output is driven only in the two shifting states.
// (R06) Serial input feeds whichever register is currently selected.
// (R07) Controller steps by the mode select level sampled at each rising edge.
// (R08) Reset state follows test reset or five consecutive mode-select ones.
// (R09) Only DC pin boundary scan; no AC test mode exists.
// (R10) Identification register lets the tester read the part number.
// (R11) Boundary chain sits on the serial path only for EXTEST or SAMPLE/PRELOAD.
// (R12) After EXTEST update, held boundary values drive outputs at once; here the pins change on the fourth ref_clk edge after the update toggle.
// (R13) Every boundary update latch loads on the falling test clock edge.
// (R14) Bypass, boundary and identification registers share one serial input and output.
// (R15) Receive lanes get observe-only cells; transmit pairs share one control cell.
// (R16) Bypass is one bit, captures zero, adds one clock of delay.
`timescale 1ns/1ps

module bstp_test_port
	import bstp_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                tck,
	input  wire logic                testRstN,
	input  wire logic                tms,
	input  wire logic                tdi,
	output logic                     tdo,
	output logic                     tdoOe,
	input  wire logic [RX_LANES-1:0] rxLanePin,
	input  wire logic [TX_LANES-1:0] coreTxData,
	input  wire logic                coreTxEn,
	output logic      [TX_LANES-1:0] txPinOut,
	output logic                     txPinOe
);

	// ----------------------------------------------------------------
	// Controller
	// ----------------------------------------------------------------
	bstp_state_t tapState;

	bstp_tap_ctrl u_ctrl (
		.tck      (tck),
		.testRstN (testRstN),
		.tms      (tms),
		.tapState (tapState)
	);

	// ----------------------------------------------------------------
	// Test clock domain, rising edge
	// ----------------------------------------------------------------
	logic [IR_W-1:0]     irShift_q,  irShift_d;
	logic [IR_W-1:0]     instr_q,    instr_d;
	logic                bypass_q,   bypass_d;
	logic [ID_W-1:0]     idShift_q,  idShift_d;
	logic [CHAIN_W-1:0]  chain_q,    chain_d;
	logic                extestSel_q, extestSel_d;
	logic [RX_LANES-1:0] rxSync1_q,  rxSync2_q;
	logic [UPD_W-1:0]    txSync1_q,  txSync2_q;
	logic                selChain;
	logic                selId;
	logic                selByp;

	// Unknown codes fall back to bypass; there is no AC-coupled test instruction
	always_comb begin
		selChain = (instr_q == INS_EXTEST) || (instr_q == INS_SAMPLE);  // R11
		selId    = (instr_q == INS_IDCODE);                             // R10
		selByp   = !selChain && !selId;                                 // R09
	end

	always_comb begin
		irShift_d = irShift_q;
		instr_d   = instr_q;
		bypass_d  = bypass_q;
		idShift_d = idShift_q;
		chain_d   = chain_q;
		unique case (tapState)
			ST_TLR:   instr_d   = INS_IDCODE;
			ST_CAPIR: irShift_d = IR_CAPTURE;
			ST_SHIR:  irShift_d = {tdi, irShift_q[IR_W-1:1]};  // R06
			ST_UPDIR: instr_d   = irShift_q;                   // R01
			ST_CAPDR: begin
				if (selByp) begin
					bypass_d = BYP_CAPTURE;  // R16
				end
				if (selId) begin
					idShift_d = ID_VALUE;  // R10
				end
				if (selChain) begin
					chain_d = {txSync2_q, rxSync2_q};  // R15
				end
			end
			ST_SHDR: begin
				if (selByp) begin
					bypass_d = tdi;  // R16
				end
				if (selId) begin
					idShift_d = {tdi, idShift_q[ID_W-1:1]};  // R06
				end
				if (selChain) begin
					chain_d = {tdi, chain_q[CHAIN_W-1:1]};  // R06
				end
			end
			default: begin
			end
		endcase
		// Registered here so the core side never synchronises a decoder glitch
		extestSel_d = (instr_d == INS_EXTEST);
	end

	// Lane pins are foreign to the test clock; two stages before capture
	always_ff @(posedge tck or negedge testRstN) begin
		if (!testRstN) begin
			irShift_q <= IR_CAPTURE;
			instr_q   <= INS_IDCODE;
			bypass_q  <= BYP_CAPTURE;
			idShift_q <= ID_VALUE;
			chain_q     <= '0;
			extestSel_q <= 1'h0;
			rxSync1_q <= '0;
			rxSync2_q <= '0;
			txSync1_q <= '0;
			txSync2_q <= '0;
		end else begin
			irShift_q <= irShift_d;  // R03
			instr_q   <= instr_d;
			bypass_q  <= bypass_d;
			idShift_q <= idShift_d;
			chain_q     <= chain_d;
			extestSel_q <= extestSel_d;
			rxSync1_q <= rxLanePin;
			rxSync2_q <= rxSync1_q;
			txSync1_q <= {txPinOe, txPinOut};
			txSync2_q <= txSync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Test clock domain, falling edge
	// ----------------------------------------------------------------
	logic             tdo_d;
	logic             tdoOe_d;
	logic [UPD_W-1:0] updLatch_q, updLatch_d;
	logic             updTgl_q,   updTgl_d;

	always_comb begin
		tdoOe_d    = (tapState == ST_SHDR) || (tapState == ST_SHIR);  // R05
		updLatch_d = updLatch_q;
		updTgl_d   = updTgl_q;
		if (tapState == ST_SHIR) begin
			tdo_d = irShift_q[0];
		end else if (selChain) begin
			tdo_d = chain_q[0];  // R14
		end else if (selId) begin
			tdo_d = idShift_q[0];
		end else begin
			tdo_d = bypass_q;
		end
		if (tapState == ST_UPDDR && selChain) begin
			updLatch_d = chain_q[CHAIN_W-1:CHAIN_TX_LO];  // R13
			updTgl_d   = !updTgl_q;
		end
	end

	always_ff @(negedge tck or negedge testRstN) begin
		if (!testRstN) begin
			tdo        <= 1'h0;
			tdoOe      <= 1'h0;
			updLatch_q <= '0;
			updTgl_q   <= 1'h0;
		end else begin
			tdo        <= tdo_d;  // R04
			tdoOe      <= tdoOe_d;
			updLatch_q <= updLatch_d;
			updTgl_q   <= updTgl_d;
		end
	end

	// ----------------------------------------------------------------
	// Core clock domain
	// ----------------------------------------------------------------
	logic             extest1_q,  extest2_q;
	logic             tgl1_q,     tgl2_q,    tgl3_q;
	logic [UPD_W-1:0] updHold_q,  updHold_d;
	logic [TX_LANES-1:0] txOut_d;
	logic             txOe_d;

	// The latch word is stable for many core cycles after its toggle, so it is
	// taken whole once the synchronised toggle is seen
	always_comb begin
		updHold_d = updHold_q;
		if (tgl2_q != tgl3_q) begin
			updHold_d = updLatch_q;
		end
		if (extest2_q) begin
			txOut_d = updHold_q[TX_LANES-1:0];  // R12
			txOe_d  = updHold_q[TX_LANES];
		end else begin
			txOut_d = coreTxData;
			txOe_d  = coreTxEn;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			extest1_q <= 1'h0;
			extest2_q <= 1'h0;
			tgl1_q    <= 1'h0;
			tgl2_q    <= 1'h0;
			tgl3_q    <= 1'h0;
			updHold_q <= '0;
			txPinOut  <= '0;
			txPinOe   <= 1'h0;
		end else begin
			extest1_q <= extestSel_q;
			extest2_q <= extest1_q;
			tgl1_q    <= updTgl_q;
			tgl2_q    <= tgl1_q;
			tgl3_q    <= tgl2_q;
			updHold_q <= updHold_d;
			txPinOut  <= txOut_d;
			txPinOe   <= txOe_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence tmsOnesSeq;
		tms [*5];
	endsequence

	sequence bypassShiftSeq;
		(tapState == ST_SHDR && selByp) [*2];
	endsequence

	AST_FIVE_ONES: assert property (  // R08
		@(posedge tck) disable iff (!testRstN) tmsOnesSeq |=> tapState == ST_TLR)
		else $error("five mode-select ones did not reach reset state");

	AST_TDO_ENABLE: assert property (  // R05
		@(posedge tck) disable iff (!testRstN)
		tdoOe == (tapState == ST_SHDR || tapState == ST_SHIR))
		else $error("serial output enabled outside a shifting state");

	AST_BYPASS_DELAY: assert property (  // R16
		@(posedge tck) disable iff (!testRstN) bypassShiftSeq |-> bypass_q == $past(tdi))
		else $error("bypass did not delay input by one clock");

	AST_BYPASS_ZERO: assert property (  // R16
		@(posedge tck) disable iff (!testRstN)
		(tapState == ST_CAPDR && selByp) |=> !bypass_q)
		else $error("bypass did not capture zero");

	AST_IR_LOAD: assert property (  // R01
		@(posedge tck) disable iff (!testRstN)
		tapState == ST_UPDIR |=> instr_q == $past(irShift_q))
		else $error("instruction not loaded at update");

	AST_IR_SHIFT: assert property (  // R06
		@(posedge tck) disable iff (!testRstN)
		tapState == ST_SHIR |=> irShift_q[IR_W-1] == $past(tdi))
		else $error("instruction shift lost serial input");

	AST_ID_CAPTURE: assert property (  // R10
		@(posedge tck) disable iff (!testRstN)
		(tapState == ST_CAPDR && selId) |=> idShift_q == ID_VALUE)
		else $error("identification value not captured");

	AST_CHAIN_PATH: assert property (  // R11
		@(posedge tck) disable iff (!testRstN)
		(tapState == ST_SHDR && !selChain) |=> $stable(chain_q))
		else $error("boundary chain shifted while not selected");

	AST_EXTEST_DRIVE: assert property (  // R12
		@(posedge ref_clk) disable iff (!rst_n)
		extest2_q |=> txPinOut == $past(updHold_q[TX_LANES-1:0]))
		else $error("pins not driven from held boundary values");

endmodule : bstp_test_port

// >>> tb/bstp_tester_model.sv
/*
 * Board tester model that drives four of the five serial test pins of the test port and samples the serial output.
 * Assumes the bench calls its tasks one at a time; the test clock stands still between frames.
 */
`timescale 1ns/1ps

module bstp_tester_model (
	output logic      tck,
	output logic      testRstN,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdoOe
);
	// Counts protocol faults seen on the serial output; the bench reads it
	int pinFaults;
	// Output enable seen at the same point as the data bit, after the fall has settled
	logic oeSeen;

	initial begin
		oeSeen = 1'h0;
		tck = 1'h0;
		testRstN = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		pinFaults = 0;
	end

	// ----------------------------------------------------------------
	// One test clock: drive after the fall, sample midway between the fall and the rise
	// ----------------------------------------------------------------
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#20;
		q = tdo;
		oeSeen = tdoOe;
		#20 tck = 1'h1;
		#1;
		if (tdo !== q) pinFaults++;
		#39 tck = 1'h0;
	endtask : tick

	task automatic testReset();
		logic q;
		testRstN = 1'h0;
		#100;
		testRstN = 1'h1;
		#40;
		// Leave reset state so every scan starts from Run-Test/Idle
		tick(1'h0, 1'h1, q);
	endtask : testReset

	task automatic tmsReset();
		logic q;
		for (int i = 0; i < 5; i++) tick(1'h1, 1'h1, q);
		tick(1'h0, 1'h1, q);
		tms = 1'h1;
	endtask : tmsReset

	// ----------------------------------------------------------------
	// Full scan from Run-Test/Idle back to Run-Test/Idle, LSB first
	// ----------------------------------------------------------------
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic q;
		dout = 64'h0;
		tick(1'h1, 1'h1, q);
		if (ir) tick(1'h1, 1'h1, q);
		tick(1'h0, 1'h1, q);
		tick(1'h0, 1'h1, q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
			if (oeSeen !== 1'h1) pinFaults++;
		end
		tick(1'h1, 1'h1, q);
		if (oeSeen !== 1'h0) pinFaults++;
		tick(1'h0, 1'h1, q);
		// Released pins rest at their pull-up level
		tms = 1'h1;
		tdi = 1'h1;
	endtask : scan

endmodule : bstp_tester_model

// >>> tb/boundary_scan_test_port_bench.sv
/*
 * Self-checking bench for the boundary-scan test port with a tester model on the serial pins.
 * Assumes the package constants for instruction codes, capture values and chain layout.
 */
`timescale 1ns/1ps

module boundary_scan_test_port_bench;
	import bstp_pkg::*;

	logic                ref_clk;
	logic                rst_n;
	logic                tck;
	logic                testRstN;
	logic                tms;
	logic                tdi;
	logic                tdo;
	logic                tdoOe;
	logic [RX_LANES-1:0] rxLanePin;
	logic [TX_LANES-1:0] coreTxData;
	logic                coreTxEn;
	logic [TX_LANES-1:0] txPinOut;
	logic                txPinOe;
	logic [63:0]         d;
	int                  nErrors;
	int                  nTests;

	bstp_test_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .testRstN(testRstN),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .rxLanePin(rxLanePin),
		.coreTxData(coreTxData), .coreTxEn(coreTxEn), .txPinOut(txPinOut), .txPinOe(txPinOe));

	bstp_tester_model tester (.tck(tck), .testRstN(testRstN), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdoOe(tdoOe));

	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Shared checking and closing
	// ----------------------------------------------------------------
	task automatic checkVal(input string what, input logic [63:0] exp, input logic [63:0] got);
		nTests++;
		if (got !== exp) begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : checkVal

	task automatic completeRun();
		$display("Comparisons %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : completeRun

	// Pins cross into the core clock, so allow a bounded settling time
	task automatic waitPins(input logic [3:0] v, input logic e);
		int k;
		k = 0;
		while ((txPinOut !== v || txPinOe !== e) && k < 20) begin
			@(negedge ref_clk);
			k++;
		end
		checkVal("txPins", {59'h0, e, v}, {59'h0, txPinOe, txPinOut});
		if (k >= 20) completeRun();
	endtask : waitPins

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic testIdcode();
		tester.testReset();
		checkVal("tdoOeIdle", 64'h0, {63'h0, tdoOe});
		tester.scan(1'h0, 32, 64'h0, d);
		checkVal("idcode", {32'h0, ID_VALUE}, d);
		$display("test idcode done");
	endtask : testIdcode

	task automatic testBypass();
		logic [IR_W-1:0] codes [2];
		codes[0] = INS_BYPASS;
		codes[1] = 6'h15;
		foreach (codes[i]) begin
			tester.scan(1'h1, 6, {58'h0, codes[i]}, d);
			checkVal("irCapture", {58'h0, IR_CAPTURE}, d);
			tester.scan(1'h0, 8, 64'hA5, d);
			checkVal("bypassOut", {56'h0, 8'h4A}, d);
		end
		tester.tmsReset();
		tester.scan(1'h0, 32, 64'h0, d);
		checkVal("idAfterTms", {32'h0, ID_VALUE}, d);
		$display("test bypass done");
	endtask : testBypass

	task automatic testExtest();
		@(negedge ref_clk);
		rxLanePin = 4'hA;
		coreTxData = 4'h5;
		coreTxEn = 1'h1;
		waitPins(4'h5, 1'h1);
		tester.scan(1'h1, 6, {58'h0, INS_SAMPLE}, d);
		tester.scan(1'h0, CHAIN_W, 64'h1C0, d);
		checkVal("sampleCapture", 64'h15A, d);
		checkVal("tdoFaults", 64'h0, 64'(tester.pinFaults));
		waitPins(4'h5, 1'h1);
		tester.scan(1'h1, 6, {58'h0, INS_EXTEST}, d);
		waitPins(4'hC, 1'h1);
		tester.scan(1'h0, CHAIN_W, 64'h0, d);
		checkVal("extestCapture", 64'h1CA, d);
		waitPins(4'h0, 1'h0);
		tester.testReset();
		waitPins(4'h5, 1'h1);
		$display("test extest done");
	endtask : testExtest

	initial begin
		nErrors = 0;
		nTests = 0;
		rst_n = 1'h0;
		rxLanePin = 4'h0;
		coreTxData = 4'h0;
		coreTxEn = 1'h0;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'h1;
		testIdcode();
		testBypass();
		testExtest();
		completeRun();
	end

endmodule : boundary_scan_test_port_bench
